// ### include/smc_pkg.sv
`default_nettype none
package smc_pkg;
  // ----------------------------------------------------------------
  // Register commands and layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SLEEP_MODE = 8'h01; // Sleep-mode selector
  localparam logic [7:0] CMD_IDLE_TIME = 8'h02; // Idle time before sleep
  localparam logic [7:0] SLEEP_MODE_RST = 8'h00; // Sleep disabled
  localparam logic [15:0] IDLE_TIME_RST = 16'h0064; // 10 s in 100 ms units
  localparam logic [15:0] IDLE_TIME_MIN = 16'h0010; // Smallest accepted value
  localparam logic [1:0] BYTES_SLEEP_MODE = 2'h1; // Read length, selector
  localparam logic [1:0] BYTES_IDLE_TIME = 2'h2; // Read length, idle time
  localparam logic [1:0] BYTES_NONE = 2'h0; // Read length, unmapped

  // ----------------------------------------------------------------
  // Sleep-mode codes
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_OFF = 8'h00; // Always active
  localparam logic [7:0] MODE_PIN = 8'h01; // Pin controlled sleep
  localparam logic [7:0] MODE_SERIAL = 8'h02; // Serial-port sleep
  localparam logic [7:0] MODE_CYC_FIRST = 8'h03; // Cyclic 0.5 s
  localparam logic [7:0] MODE_MAX = 8'h08; // Cyclic 16 s

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 250; // Module clock rate
  localparam int unsigned TICK_MS = 100; // Timer unit in ms
  localparam int unsigned TICK_CYCLES_DFLT = TICK_MS * 1000 * CLK_MHZ; // Cycles per unit
  localparam int unsigned LISTEN_MS = 100; // Listen window after a cyclic wake
  localparam logic [15:0] LISTEN_TICKS = 16'(LISTEN_MS / TICK_MS); // Window in units
  localparam int unsigned CYC_BASE_MS = 500; // Shortest cyclic interval
  localparam logic [15:0] CYC_BASE_TICKS = 16'(CYC_BASE_MS / TICK_MS); // In units

  // Controller states
  typedef enum logic [2:0] {
    S_ACTIVE,
    S_PIN_SLEEP,
    S_SER_SLEEP,
    S_CYC_SLEEP,
    S_LISTEN,
    S_RECEIVE
  } smc_state_t;

  // True for the six cyclic codes
  function automatic logic is_cyclic(input logic [7:0] m);
    return (m >= MODE_CYC_FIRST) && (m <= MODE_MAX);
  endfunction

  // Cyclic interval in units; doubles with each code step
  function automatic logic [15:0] cyc_ticks(input logic [7:0] m);
    logic [3:0] sh;
    sh = m[3:0] - MODE_CYC_FIRST[3:0];
    return CYC_BASE_TICKS << sh;
  endfunction
endpackage
`default_nettype wire

// ### include/smc_tmr_if.sv
`default_nettype none
// Carries the restart request and the elapsed unit count
interface smc_tmr_if;
  logic clr; // Restart the timer
  logic [15:0] ticks; // Elapsed 100 ms units, saturating
  modport ctrl (output clr, input ticks);
  modport tmr (input clr, output ticks);
endinterface
`default_nettype wire

// ### hw/smc_timer.sv
`default_nettype none
module smc_timer #(
  parameter int unsigned TICK_CYCLES = smc_pkg::TICK_CYCLES_DFLT
) (
  input wire logic clk_sys, // Module clock
  input wire logic rst, // Synchronous reset, high
  smc_tmr_if.tmr bus // Restart in, count out
);
  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (TICK_CYCLES < 1) begin : g_chk
    $error("TICK_CYCLES must be at least one");
  end

  logic [31:0] pre_q; // Cycle prescaler
  logic [15:0] cnt_q; // Unit count
  logic unit_end; // Last cycle of a unit

  assign unit_end = (pre_q == 32'(TICK_CYCLES - 1));
  assign bus.ticks = cnt_q;

  // Prescaler restarts with the count so each unit is whole
  always_ff @(posedge clk_sys)
  begin
    if (rst || bus.clr)
    begin
      pre_q <= 32'h0;
    end
    else if (unit_end)
    begin
      pre_q <= 32'h0;
    end
    else
    begin
      pre_q <= pre_q + 32'h1;
    end
  end

  // Unit counter; saturates so a long silence never wraps back to zero
  always_ff @(posedge clk_sys)
  begin
    if (rst || bus.clr)
    begin
      cnt_q <= 16'h0;
    end
    else if (unit_end && (cnt_q != 16'hffff))
    begin
      cnt_q <= cnt_q + 16'h1;
    end
  end
endmodule
`default_nettype wire

// ### hw/smc_ctrl.sv
`default_nettype none
module smc_ctrl #(
  parameter int unsigned TICK_CYCLES = smc_pkg::TICK_CYCLES_DFLT
) (
  input wire logic clk_sys, // Module clock
  input wire logic rst, // Synchronous reset, high
  input wire logic [7:0] reg_cmd, // Register command code
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [15:0] reg_wdata, // Write value
  output logic [15:0] reg_rdata_q, // Read value
  output logic reg_rvalid_q, // Read answer pulse
  output logic [1:0] reg_rbytes_q, // Bytes in the read answer
  output logic reg_refused_q, // Refused access pulse
  input wire logic sleep_pin, // Sleep pin, asynchronous
  input wire logic pin_wakeup_enable, // Pin wake from cyclic sleep
  input wire logic serial_char_valid, // Character received on serial input
  input wire logic serial_activity, // Serial send or receive
  input wire logic rf_activity, // Radio send or receive
  input wire logic rf_packet_valid, // Valid radio packet seen
  input wire logic rf_init_detect, // Wake-up initializer seen
  input wire logic rf_init_done, // Wake-up initializer ended
  output logic cts_n_q, // Flow control, high blocks host
  output logic power_indicator_q, // High while awake
  output logic serial_tx_enable_q, // Serial data may be sent on air
  output logic rf_rx_enable_q, // Receive mode
  output logic rx_sync_q, // Synchronized to a transmitter
  output logic asleep_q // Any sleep state
);
  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (TICK_CYCLES < 1) begin : g_chk
    $error("TICK_CYCLES must be at least one");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] sleep_mode_select_q; // Sleep-mode selector
  logic [15:0] idle_time_before_sleep_q; // Idle time in units
  logic pin_meta_q; // First synchroniser stage
  logic pin_s_q; // Synchronised sleep pin
  smc_pkg::smc_state_t state_q; // Current state
  smc_pkg::smc_state_t state_d; // Next state
  logic cyc; // Cyclic mode selected
  logic awake_act; // Activity while awake
  logic idle_done; // Idle time has passed
  logic pin_wake; // Pin wake from cyclic sleep
  logic sleep_d; // Next state is a sleep state
  logic wr_ok; // Write accepted
  logic sync_wait_q; // Initializer in progress
  smc_tmr_if tmr_bus(); // Timer link

  // Shared inactivity, interval and listen timer
  smc_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .bus(tmr_bus.tmr)
  );

  // ----------------------------------------------------------------
  // Sleep pin synchroniser
  // ----------------------------------------------------------------
  // Two stages; only the second is read
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pin_meta_q <= 1'b0;
      pin_s_q <= 1'b0;
    end
    else
    begin
      pin_meta_q <= sleep_pin;
      pin_s_q <= pin_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Out-of-range writes are dropped whole, never clipped
  always_comb
  begin
    wr_ok = 1'b0;
    if (reg_cmd == smc_pkg::CMD_SLEEP_MODE)
    begin
      wr_ok = (reg_wdata <= 16'(smc_pkg::MODE_MAX));
    end
    else if (reg_cmd == smc_pkg::CMD_IDLE_TIME)
    begin
      wr_ok = (reg_wdata >= smc_pkg::IDLE_TIME_MIN);
    end
  end

  // Selector register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sleep_mode_select_q <= smc_pkg::SLEEP_MODE_RST;
    end
    else if (reg_wr && wr_ok && (reg_cmd == smc_pkg::CMD_SLEEP_MODE))
    begin
      sleep_mode_select_q <= reg_wdata[7:0];
    end
  end

  // Idle-time register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      idle_time_before_sleep_q <= smc_pkg::IDLE_TIME_RST;
    end
    else if (reg_wr && wr_ok && (reg_cmd == smc_pkg::CMD_IDLE_TIME))
    begin
      idle_time_before_sleep_q <= reg_wdata;
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_rvalid_q <= 1'b0;
      reg_rdata_q <= 16'h0;
      reg_rbytes_q <= smc_pkg::BYTES_NONE;
    end
    else
    begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd && (reg_cmd == smc_pkg::CMD_SLEEP_MODE))
      begin
        reg_rdata_q <= {8'h0, sleep_mode_select_q};
        reg_rbytes_q <= smc_pkg::BYTES_SLEEP_MODE;
      end
      else if (reg_rd && (reg_cmd == smc_pkg::CMD_IDLE_TIME))
      begin
        reg_rdata_q <= idle_time_before_sleep_q;
        reg_rbytes_q <= smc_pkg::BYTES_IDLE_TIME;
      end
      else if (reg_rd)
      begin
        // Unmapped command answers zero bytes
        reg_rdata_q <= 16'h0;
        reg_rbytes_q <= smc_pkg::BYTES_NONE;
      end
    end
  end

  // Refused pulse for a bad write or an unmapped read
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_refused_q <= 1'b0;
    end
    else
    begin
      reg_refused_q <= (reg_wr && !wr_ok) || (reg_rd &&
        (reg_cmd != smc_pkg::CMD_SLEEP_MODE) && (reg_cmd != smc_pkg::CMD_IDLE_TIME));
    end
  end

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  assign cyc = smc_pkg::is_cyclic(sleep_mode_select_q);
  assign awake_act = serial_activity || rf_activity;
  // Activity in the same cycle vetoes the timeout
  assign idle_done = (tmr_bus.ticks >= idle_time_before_sleep_q) && !awake_act;
  // Outside pin mode the pin is only looked at when pin wake is enabled
  assign pin_wake = pin_wakeup_enable && !pin_s_q;

  // Next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      smc_pkg::S_ACTIVE:
      begin
        // Idle time matters only in serial and cyclic modes
        if ((sleep_mode_select_q == smc_pkg::MODE_PIN) && pin_s_q)
        begin
          state_d = smc_pkg::S_PIN_SLEEP;
        end
        else if ((sleep_mode_select_q == smc_pkg::MODE_SERIAL) && idle_done)
        begin
          state_d = smc_pkg::S_SER_SLEEP;
        end
        else if (cyc && idle_done)
        begin
          state_d = smc_pkg::S_CYC_SLEEP;
        end
      end
      smc_pkg::S_PIN_SLEEP:
      begin
        // Leaving pin mode also wakes; elsewhere the pin acts only through pin_wake in cyclic modes
        if ((sleep_mode_select_q != smc_pkg::MODE_PIN) || !pin_s_q)
        begin
          state_d = smc_pkg::S_ACTIVE;
        end
      end
      smc_pkg::S_SER_SLEEP:
      begin
        if ((sleep_mode_select_q != smc_pkg::MODE_SERIAL) || serial_char_valid)
        begin
          state_d = smc_pkg::S_ACTIVE;
        end
      end
      smc_pkg::S_CYC_SLEEP:
      begin
        if (!cyc || pin_wake)
        begin
          state_d = smc_pkg::S_ACTIVE;
        end
        else if (tmr_bus.ticks >= smc_pkg::cyc_ticks(sleep_mode_select_q))
        begin
          state_d = smc_pkg::S_LISTEN;
        end
      end
      smc_pkg::S_LISTEN:
      begin
        // Host data during the window keeps the module awake
        if (!cyc || pin_wake || serial_activity)
        begin
          state_d = smc_pkg::S_ACTIVE;
        end
        else if (rf_packet_valid || rf_init_detect)
        begin
          state_d = smc_pkg::S_RECEIVE;
        end
        else if (tmr_bus.ticks >= smc_pkg::LISTEN_TICKS)
        begin
          state_d = smc_pkg::S_CYC_SLEEP;
        end
      end
      smc_pkg::S_RECEIVE:
      begin
        if (!cyc || serial_activity)
        begin
          state_d = smc_pkg::S_ACTIVE;
        end
        else if (idle_done)
        begin
          state_d = smc_pkg::S_CYC_SLEEP;
        end
      end
      default:
      begin
        state_d = smc_pkg::S_ACTIVE;
      end
    endcase
  end

  // Timer restarts on every state change and on activity while awake
  assign tmr_bus.clr = (state_d != state_q) || (!asleep_q && awake_act);

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q <= smc_pkg::S_ACTIVE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sleep_d = (state_d == smc_pkg::S_PIN_SLEEP) || (state_d == smc_pkg::S_SER_SLEEP) ||
    (state_d == smc_pkg::S_CYC_SLEEP);

  // Registered from the next state so pins track the state register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      asleep_q <= 1'b0;
      cts_n_q <= 1'b0;
      power_indicator_q <= 1'b1;
      serial_tx_enable_q <= 1'b1;
      rf_rx_enable_q <= 1'b0;
    end
    else
    begin
      asleep_q <= sleep_d;
      cts_n_q <= sleep_d;
      power_indicator_q <= !sleep_d;
      serial_tx_enable_q <= !sleep_d;
      rf_rx_enable_q <= (state_d == smc_pkg::S_RECEIVE);
    end
  end

  // Initializer tracking: payload reception starts once it ends
  always_ff @(posedge clk_sys)
  begin
    if (rst || sleep_d)
    begin
      sync_wait_q <= 1'b0;
      rx_sync_q <= 1'b0;
    end
    else if (rf_init_detect)
    begin
      sync_wait_q <= 1'b1;
      rx_sync_q <= 1'b0;
    end
    else if (sync_wait_q && rf_init_done)
    begin
      sync_wait_q <= 1'b0;
      rx_sync_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_mode_range;
    sleep_mode_select_q <= smc_pkg::MODE_MAX;
  endproperty
  a_mode_range: assert property (p_mode_range) else $error("selector out of range");

  property p_sel_read;
    reg_rd && (reg_cmd == smc_pkg::CMD_SLEEP_MODE) |=>
      reg_rvalid_q && (reg_rbytes_q == smc_pkg::BYTES_SLEEP_MODE) && (reg_rdata_q[15:8] == 8'h0);
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("selector read not one byte");

  property p_pin_wake;
    (state_q == smc_pkg::S_PIN_SLEEP) && !pin_s_q |=> (state_q == smc_pkg::S_ACTIVE);
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("pin low did not wake");

  property p_pin_ignored;
    (sleep_mode_select_q != smc_pkg::MODE_PIN) && (state_q != smc_pkg::S_PIN_SLEEP) |=>
      (state_q != smc_pkg::S_PIN_SLEEP);
  endproperty
  a_pin_ignored: assert property (p_pin_ignored) else $error("pin sleep outside pin mode");

  property p_sleep_pins;
    asleep_q |-> cts_n_q && !power_indicator_q && !serial_tx_enable_q;
  endproperty
  a_sleep_pins: assert property (p_sleep_pins) else $error("sleep pins wrong");

  property p_ser_sleep;
    (state_q == smc_pkg::S_ACTIVE) && (sleep_mode_select_q == smc_pkg::MODE_SERIAL) && idle_done
      |=> (state_q == smc_pkg::S_SER_SLEEP) && asleep_q;
  endproperty
  a_ser_sleep: assert property (p_ser_sleep) else $error("no serial sleep after idle");

  property p_ser_wake;
    (state_q == smc_pkg::S_SER_SLEEP) && serial_char_valid |=> !asleep_q ##1 !cts_n_q;
  endproperty
  a_ser_wake: assert property (p_ser_wake) else $error("character did not wake");

  property p_listen_pins;
    (state_q == smc_pkg::S_LISTEN) |-> !cts_n_q && serial_tx_enable_q && power_indicator_q;
  endproperty
  a_listen_pins: assert property (p_listen_pins) else $error("listen pins wrong");

  property p_listen_end;
    (state_q == smc_pkg::S_LISTEN) && cyc && !pin_wake && !serial_activity && !rf_packet_valid &&
      !rf_init_detect && (tmr_bus.ticks >= smc_pkg::LISTEN_TICKS) |=> (state_q == smc_pkg::S_CYC_SLEEP);
  endproperty
  a_listen_end: assert property (p_listen_end) else $error("listen did not end");

  property p_pkt_rx;
    (state_q == smc_pkg::S_LISTEN) && cyc && !pin_wake && !serial_activity && rf_packet_valid
      |=> rf_rx_enable_q;
  endproperty
  a_pkt_rx: assert property (p_pkt_rx) else $error("packet did not start receive");

  property p_cyc_pin;
    (state_q == smc_pkg::S_CYC_SLEEP) && pin_wake |=> (state_q == smc_pkg::S_ACTIVE);
  endproperty
  a_cyc_pin: assert property (p_cyc_pin) else $error("pin wake ignored");

  property p_idle_min;
    reg_wr && (reg_cmd == smc_pkg::CMD_IDLE_TIME) && (reg_wdata < smc_pkg::IDLE_TIME_MIN)
      |=> $stable(idle_time_before_sleep_q) && reg_refused_q;
  endproperty
  a_idle_min: assert property (p_idle_min) else $error("short idle time accepted");

  property p_sync;
    sync_wait_q && rf_init_done && !rf_init_detect && !sleep_d |=> rx_sync_q;
  endproperty
  a_sync: assert property (p_sync) else $error("no sync after initializer");

  c_pin_sleep: cover property ((state_q == smc_pkg::S_ACTIVE) ##1 (state_q == smc_pkg::S_PIN_SLEEP));
  c_listen_rx: cover property ((state_q == smc_pkg::S_LISTEN) ##1 (state_q == smc_pkg::S_RECEIVE));
  c_listen_back: cover property ((state_q == smc_pkg::S_LISTEN) ##1 (state_q == smc_pkg::S_CYC_SLEEP));
  c_ser_wake: cover property ((state_q == smc_pkg::S_SER_SLEEP) ##1 (state_q == smc_pkg::S_ACTIVE));
endmodule
`default_nettype wire

// ### verification/smc_far_end.sv
`default_nettype none
// ----------------------------------------
// Host serial port and remote transmitter
// ----------------------------------------
module smc_far_end #(
  parameter int unsigned INIT_CYCLES = 24 // Above the 20-cycle cyclic interval
) (
  input wire logic clk_sys, // Module clock
  input wire logic rst, // Synchronous reset, high
  input wire logic send_char, // Host sends one character
  input wire logic start_tx, // Remote starts a transmission
  input wire logic rx_awake, // Receiver is listening
  output logic serial_char_valid, // Character on serial input
  output logic serial_activity, // Serial traffic
  output logic rf_activity, // Radio traffic heard
  output logic rf_packet_valid, // Payload arrived
  output logic rf_init_detect, // Initializer heard
  output logic rf_init_done // Initializer over
);
  int unsigned cnt; // Initializer cycles left
  logic seen; // Initializer already reported
  // Host characters go out even while flow control blocks, to wake the port
  always_ff @(posedge clk_sys)
  begin
    serial_char_valid <= send_char && !rst;
    serial_activity <= send_char && !rst;
  end
  // Initializer then payload; a sleeping receiver hears nothing of it
  always_ff @(posedge clk_sys)
  begin
    rf_init_detect <= 1'b0;
    rf_init_done <= 1'b0;
    rf_packet_valid <= rf_init_done && !rst;
    if (rst)
    begin
      cnt <= 0;
      seen <= 1'b0;
    end
    else if (start_tx)
    begin
      cnt <= INIT_CYCLES;
      seen <= 1'b0;
    end
    else if (cnt != 0)
    begin
      cnt <= cnt - 1;
      if (rx_awake && !seen)
      begin
        rf_init_detect <= 1'b1;
        seen <= 1'b1;
      end
      rf_init_done <= (cnt == 1) && seen;
    end
  end
  // Traffic is only heard once the receiver has caught the initializer
  assign rf_activity = (seen && (cnt != 0)) || rf_packet_valid;
endmodule
`default_nettype wire

// ### verification/sleep_mode_controller_test.sv
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
  $display("ERROR at %0t: got %h expected %h", $time, (a), (e)); end end
module sleep_mode_controller_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned TK = 4; // Cycles per 100 ms unit, shortened
  localparam int unsigned INIT = 24; // Initializer length in cycles
  typedef struct {logic [7:0] cmd; logic [15:0] wd; logic rf; logic [15:0] rd; logic [1:0] nb;} smc_row_t;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_cmd = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic sleep_pin = 1'b0;
  logic pin_wakeup_enable = 1'b0;
  logic send_char = 1'b0;
  logic start_tx = 1'b0;
  logic [15:0] reg_rdata_q;
  logic [1:0] reg_rbytes_q;
  logic reg_rvalid_q, reg_refused_q, cts_n_q, power_indicator_q, serial_tx_enable_q;
  logic rf_rx_enable_q, rx_sync_q, asleep_q;
  logic serial_char_valid, serial_activity, rf_activity, rf_packet_valid, rf_init_detect, rf_init_done;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  smc_row_t rows[14];

  smc_ctrl #(.TICK_CYCLES(TK)) dut (.clk_sys(clk_sys), .rst(rst), .reg_cmd(reg_cmd), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .reg_rbytes_q(reg_rbytes_q), .reg_refused_q(reg_refused_q), .sleep_pin(sleep_pin),
    .pin_wakeup_enable(pin_wakeup_enable), .serial_char_valid(serial_char_valid),
    .serial_activity(serial_activity), .rf_activity(rf_activity), .rf_packet_valid(rf_packet_valid),
    .rf_init_detect(rf_init_detect), .rf_init_done(rf_init_done), .cts_n_q(cts_n_q),
    .power_indicator_q(power_indicator_q), .serial_tx_enable_q(serial_tx_enable_q),
    .rf_rx_enable_q(rf_rx_enable_q), .rx_sync_q(rx_sync_q), .asleep_q(asleep_q));
  smc_far_end #(.INIT_CYCLES(INIT)) far (.clk_sys(clk_sys), .rst(rst), .send_char(send_char),
    .start_tx(start_tx), .rx_awake(!asleep_q), .serial_char_valid(serial_char_valid),
    .serial_activity(serial_activity), .rf_activity(rf_activity), .rf_packet_valid(rf_packet_valid),
    .rf_init_detect(rf_init_detect), .rf_init_done(rf_init_done));

  // Clock and a ceiling on run length, so a hung wait still ends in the report
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      summarize();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // One register access; answer sampled 1 ns after the edge that takes it
  task acc(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= !w;
    reg_cmd <= c;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask
  // One-cycle request pulse on a far-side command
  task pulse(input logic chr);
    @(posedge clk_sys);
    if (chr) send_char <= 1'b1; else start_tx <= 1'b1;
    @(posedge clk_sys);
    send_char <= 1'b0;
    start_tx <= 1'b0;
    #1;
  endtask
  // Bounded wait for the sleep flag to reach a level; n counts the cycles
  task wait_sleep(input logic want, input int lim);
    n = 0;
    while (asleep_q !== want && n < lim)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    for (int i = 0; i < 9; i++)
      rows[i] = '{8'h01, 16'(i), 1'b0, 16'(i), 2'h1};
    rows[9] = '{8'h01, 16'h0009, 1'b1, 16'h0008, 2'h1};
    rows[10] = '{8'h02, 16'h000f, 1'b1, 16'h0064, 2'h2};
    rows[11] = '{8'h02, 16'hffff, 1'b0, 16'hffff, 2'h2};
    rows[12] = '{8'h02, 16'h0010, 1'b0, 16'h0010, 2'h2};
    rows[13] = '{8'h03, 16'h0001, 1'b1, 16'h0000, 2'h0};
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    // Every selector code, range edges of both registers, an unmapped code
    for (int i = 0; i < 14; i++)
    begin
      acc(1'b1, rows[i].cmd, rows[i].wd);
      `CHK(reg_refused_q, rows[i].rf)
      acc(1'b0, rows[i].cmd, 16'h0000);
      `CHK(reg_rvalid_q, 1'b1)
      `CHK(reg_rdata_q, rows[i].rd)
      `CHK(reg_rbytes_q, rows[i].nb)
    end
    $display("test registers done");
    // Serial-port sleep: idle time restarted by each character
    acc(1'b1, 8'h01, 16'h0002);
    pulse(1'b1);
    wait_sleep(1'b1, 400);
    `CHK((n >= 16 * TK) && (n <= 16 * TK + 8), 1'b1)
    `CHK(cts_n_q, 1'b1)
    pulse(1'b1);
    wait_sleep(1'b0, 6);
    `CHK(power_indicator_q, 1'b1)
    `CHK(cts_n_q, 1'b0)
    repeat (10 * TK) @(posedge clk_sys);
    pulse(1'b1);
    wait_sleep(1'b1, 400);
    `CHK((n >= 16 * TK) && (n <= 16 * TK + 8), 1'b1)
    $display("test serial done");
    // Pin ignored when off, then pin sleep follows the pin
    pulse(1'b1);
    acc(1'b1, 8'h01, 16'h0000);
    sleep_pin <= 1'b1;
    repeat (20) @(posedge clk_sys);
    #1;
    `CHK(asleep_q, 1'b0)
    acc(1'b1, 8'h01, 16'h0001);
    wait_sleep(1'b1, 8);
    `CHK(cts_n_q, 1'b1)
    `CHK(power_indicator_q, 1'b0)
    sleep_pin <= 1'b0;
    wait_sleep(1'b0, 8);
    `CHK(asleep_q, 1'b0)
    $display("test pin done");
    // Cyclic 0.5 s: radio idle, wake interval, listen window
    acc(1'b1, 8'h01, 16'h0003);
    pulse(1'b0);
    repeat (INIT + 3) @(posedge clk_sys);
    #1;
    `CHK(rx_sync_q, 1'b1)
    wait_sleep(1'b1, 400);
    `CHK((n + 4 >= 16 * TK) && (n <= 16 * TK + 8), 1'b1)
    `CHK(power_indicator_q, 1'b0)
    `CHK(cts_n_q, 1'b1)
    wait_sleep(1'b0, 40);
    `CHK((n + 2 >= 5 * TK) && (n <= 5 * TK + 2), 1'b1)
    `CHK(cts_n_q, 1'b0)
    `CHK(serial_tx_enable_q, 1'b1)
    wait_sleep(1'b1, 20);
    `CHK((n + 2 >= TK) && (n <= TK + 2), 1'b1)
    // Transmission starting while asleep is caught at the next wake
    pulse(1'b0);
    n = 0;
    while (rf_rx_enable_q !== 1'b1 && n < 40)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `CHK(rf_rx_enable_q, 1'b1)
    repeat (INIT) @(posedge clk_sys);
    #1;
    `CHK(rx_sync_q, 1'b1)
    wait_sleep(1'b1, 400);
    `CHK(asleep_q, 1'b1)
    `CHK(rx_sync_q, 1'b0)
    // Pin wake from cyclic sleep keeps the device up beyond a listen window
    // Pin goes high first so the synchroniser is settled before wake is enabled
    sleep_pin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    pin_wakeup_enable <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(asleep_q, 1'b1)
    sleep_pin <= 1'b0;
    wait_sleep(1'b0, 8);
    repeat (3 * TK) @(posedge clk_sys);
    #1;
    `CHK(asleep_q, 1'b0)
    // Next cyclic code doubles the wake interval
    pin_wakeup_enable <= 1'b0;
    acc(1'b1, 8'h01, 16'h0004);
    wait_sleep(1'b1, 400);
    `CHK(asleep_q, 1'b1)
    wait_sleep(1'b0, 80);
    `CHK((n + 2 >= 10 * TK) && (n <= 10 * TK + 2), 1'b1)
    $display("test cyclic done");
    // Reset in mid-run brings both registers back
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    acc(1'b0, 8'h01, 16'h0000);
    `CHK(reg_rdata_q, 16'h0000)
    `CHK(reg_rbytes_q, 2'h1)
    acc(1'b0, 8'h02, 16'h0000);
    `CHK(reg_rdata_q, 16'h0064)
    `CHK(power_indicator_q, 1'b1)
    $display("test reset done");
    summarize();
  end
endmodule
`default_nettype wire
